// [core/reg_bus_xcvr.sv]
// octal registered bus transceiver with apb control
//
// Overview of operation
// - each store captures its bus on a rising edge of its capture clock.
// - a source select low routes live opposite-bus data, high stored data.
// - changing a source select switches the driven bus without a glitch.
// - enable and direction pick the driven bus; the source selects pick live or stored data.
// - enabled, direction picks the one driven bus; the other is an input.
// - disabled, both buses are released and capture still works.
// - stored data driven out does not depend on the opposite bus level.
// - enabled, direction low drives bus a with live or stored b data.
// - disabled, the stores hold unless a capture clock rises.
// - in inverting mode the driven data is the complement of the source.
//
// The implementer's own choices: register access over APB and the address map.
module reg_bus_xcvr (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic a_side_capture_clock,
  input wire logic b_side_capture_clock,
  input wire logic [7:0] a_bus_in,
  output logic [7:0] a_bus_out,
  output logic a_bus_oe,
  input wire logic [7:0] b_bus_in,
  output logic [7:0] b_bus_out,
  output logic b_bus_oe
);
  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [7:0] a_live;
  logic [7:0] b_live;
  logic [1:0] cap_clk_sync;

  // bus data and capture clocks share the same latency, so data stays
  // aligned to the edge that samples it
  pin_sync #(.WIDTH(8)) u_sync_a (
    .clk(clk),
    .rstn(rstn),
    .pin_in(a_bus_in),
    .pin_sync_out(a_live)
  );
  pin_sync #(.WIDTH(8)) u_sync_b (
    .clk(clk),
    .rstn(rstn),
    .pin_in(b_bus_in),
    .pin_sync_out(b_live)
  );
  pin_sync #(.WIDTH(2)) u_sync_clk (
    .clk(clk),
    .rstn(rstn),
    .pin_in({b_side_capture_clock, a_side_capture_clock}),
    .pin_sync_out(cap_clk_sync)
  );

  // ********************************************************
  // apb register slave
  // ********************************************************
  logic [4:0] ctrl_reg;
  logic [4:0] ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [7:0] store_a_reg;
  logic [7:0] store_b_reg;
  logic setup;
  logic mapped;
  logic oe_n;
  logic dir;
  logic a_to_b_source_select;
  logic b_to_a_source_select;
  logic inv;

  assign oe_n = ctrl_reg[xcvr_pkg::OE_N_BIT];
  assign dir = ctrl_reg[xcvr_pkg::DIR_BIT];
  assign a_to_b_source_select = ctrl_reg[xcvr_pkg::A_TO_B_SEL_BIT];
  assign b_to_a_source_select = ctrl_reg[xcvr_pkg::B_TO_A_SEL_BIT];
  assign inv = ctrl_reg[xcvr_pkg::INV_BIT];

  // answer is prepared in the setup cycle, so pready can stay high
  always_comb begin
    setup = psel && !penable;
    mapped = (paddr == xcvr_pkg::CTRL_OFFSET) ||
             (paddr == xcvr_pkg::STORE_OFFSET) ||
             (paddr == xcvr_pkg::LIVE_OFFSET);
    ctrl_next = ctrl_reg;
    prdata_next = xcvr_pkg::WORD_ZERO;
    pslverr_next = 1'b0;
    if (psel && penable && pwrite && paddr == xcvr_pkg::CTRL_OFFSET) begin
      ctrl_next = pwdata[xcvr_pkg::CTRL_W-1:0];
    end
    if (setup) begin
      pslverr_next = !mapped;
      if (!pwrite) begin
        if (paddr == xcvr_pkg::CTRL_OFFSET) begin
          prdata_next[xcvr_pkg::CTRL_W-1:0] = ctrl_reg;
        end else if (paddr == xcvr_pkg::STORE_OFFSET) begin
          prdata_next[xcvr_pkg::DATA_W-1:0] = store_a_reg;
          prdata_next[xcvr_pkg::STORE_B_LSB +: xcvr_pkg::DATA_W] =
            store_b_reg;
        end else if (paddr == xcvr_pkg::LIVE_OFFSET) begin
          prdata_next[xcvr_pkg::DATA_W-1:0] = a_live;
          prdata_next[xcvr_pkg::STORE_B_LSB +: xcvr_pkg::DATA_W] = b_live;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= xcvr_pkg::CTRL_RESET;
      prdata_reg <= xcvr_pkg::WORD_ZERO;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = 1'b1; // zero wait states

  // ********************************************************
  // capture registers
  // ********************************************************
  logic [1:0] cap_clk_dly_reg;
  logic [1:0] cap_clk_dly_next;
  logic cap_a;
  logic cap_b;
  logic [7:0] store_a_next;
  logic [7:0] store_b_next;

  // capture runs regardless of enable or direction
  always_comb begin
    cap_clk_dly_next = cap_clk_sync;
    cap_a = cap_clk_sync[0] && !cap_clk_dly_reg[0];
    cap_b = cap_clk_sync[1] && !cap_clk_dly_reg[1];
    store_a_next = cap_a ? a_live : store_a_reg;
    store_b_next = cap_b ? b_live : store_b_reg;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cap_clk_dly_reg <= 2'h0;
      store_a_reg <= xcvr_pkg::DATA_ZERO;
      store_b_reg <= xcvr_pkg::DATA_ZERO;
    end else begin
      cap_clk_dly_reg <= cap_clk_dly_next;
      store_a_reg <= store_a_next;
      store_b_reg <= store_b_next;
    end
  end

  // ********************************************************
  // output multiplexers and drivers
  // ********************************************************
  logic [7:0] a_out_reg;
  logic [7:0] a_out_next;
  logic [7:0] b_out_reg;
  logic [7:0] b_out_next;
  logic a_oe_reg;
  logic a_oe_next;
  logic b_oe_reg;
  logic b_oe_next;
  logic [7:0] inv_mask;

  // registered mux switches in one edge: the old source is held until
  // the new one is loaded, so no intermediate value can reach a pin
  always_comb begin
    inv_mask = inv ? xcvr_pkg::DATA_ONES : xcvr_pkg::DATA_ZERO;
    a_oe_next = !oe_n && !dir;
    b_oe_next = !oe_n && dir;
    a_out_next = (b_to_a_source_select ? store_b_reg : b_live) ^
                 inv_mask;
    b_out_next = (a_to_b_source_select ? store_a_reg : a_live) ^
                 inv_mask;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      a_oe_reg <= 1'b0;
      b_oe_reg <= 1'b0;
      a_out_reg <= xcvr_pkg::DATA_ZERO;
      b_out_reg <= xcvr_pkg::DATA_ZERO;
    end else begin
      a_oe_reg <= a_oe_next;
      b_oe_reg <= b_oe_next;
      a_out_reg <= a_out_next;
      b_out_reg <= b_out_next;
    end
  end

  assign a_bus_out = a_out_reg;
  assign b_bus_out = b_out_reg;
  assign a_bus_oe = a_oe_reg;
  assign b_bus_oe = b_oe_reg;

  // ********************************************************
  // assertions
  // ********************************************************
  a_capture_a_edge: assert property (
    @(posedge clk) disable iff (!rstn)
    cap_a |=> store_a_reg == $past(a_live))
    else $error("a store missed a capture");
  a_store_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !cap_b |=> $stable(store_b_reg))
    else $error("b store changed without capture");
  a_single_drive: assert property (
    @(posedge clk) disable iff (!rstn)
    !(a_bus_oe && b_bus_oe))
    else $error("both buses driven");
  a_isolate_both: assert property (
    @(posedge clk) disable iff (!rstn)
    oe_n |=> !a_bus_oe && !b_bus_oe)
    else $error("bus driven while disabled");
  a_live_b_to_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (!oe_n && !dir && !b_to_a_source_select && !inv) |=>
      a_bus_oe && a_bus_out == $past(b_live))
    else $error("live b data not on bus a");
  a_stored_a_to_b: assert property (
    @(posedge clk) disable iff (!rstn)
    (!oe_n && dir && a_to_b_source_select && !inv) |=>
      b_bus_oe && b_bus_out == $past(store_a_reg))
    else $error("stored a data not on bus b");
  a_invert_path: assert property (
    @(posedge clk) disable iff (!rstn)
    (inv && !b_to_a_source_select) |=> a_bus_out == ~$past(b_live))
    else $error("inverted data wrong");
  a_select_switch: assert property (
    @(posedge clk) disable iff (!rstn)
    ($changed(a_to_b_source_select) && !inv) |=>
      b_bus_out == ($past(a_to_b_source_select) ?
        $past(store_a_reg) : $past(a_live)))
    else $error("select switch not clean");
  a_mode_dir: assert property (
    @(posedge clk) disable iff (!rstn)
    (!oe_n && dir) |=> b_bus_oe && !a_bus_oe)
    else $error("direction high did not drive b");
endmodule

// [core/xcvr_pkg.sv]
// constants shared by the registered bus transceiver
package xcvr_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int CTRL_W = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STORE_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] LIVE_OFFSET = 12'h008;
  // control field positions
  localparam int OE_N_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam int A_TO_B_SEL_BIT = 2;
  localparam int B_TO_A_SEL_BIT = 3;
  localparam int INV_BIT = 4;
  // outputs disabled, all else low after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONES = 8'hff;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int STORE_B_LSB = 8;
endpackage

// [core/pin_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_sync_out = sync_reg;
endmodule

// [dv/bus_party_model.sv]
// far-side bus party that shares one bus wire with the transceiver
module bus_party_model (
  input wire logic [7:0] drive_val,
  input wire logic [7:0] dev_out,
  input wire logic dev_oe,
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  // the party backs off while the device drives, so there is no contention
  assign level = dev_oe ? dev_out : drive_val;
endmodule

// [dv/tb_reg_bus_xcvr.sv]
// self-checking bench for the registered bus transceiver
module tb_reg_bus_xcvr;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, cap_a = 0, cap_b = 0;
  logic [7:0] a_val = 8'h00, b_val = 8'h00, a_lvl, b_lvl, a_out, b_out;
  logic a_oe, b_oe;
  int failures = 0, tests_run = 0, cycles = 0;
  always #4 clk = ~clk;
  reg_bus_xcvr i_dut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_side_capture_clock(cap_a), .b_side_capture_clock(cap_b),
    .a_bus_in(a_lvl), .a_bus_out(a_out), .a_bus_oe(a_oe),
    .b_bus_in(b_lvl), .b_bus_out(b_out), .b_bus_oe(b_oe));
  bus_party_model i_pa (.drive_val(a_val), .dev_out(a_out),
    .dev_oe(a_oe), .level(a_lvl));
  bus_party_model i_pb (.drive_val(b_val), .dev_out(b_out),
    .dev_oe(b_oe), .level(b_lvl));
  // ****************
  // bus tasks
  // ****************
  // setup then access; wait on pready so the master assumes no fixed latency
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // live data needs three cycles: two in the pin synchroniser, one in the output register
  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, xcvr_pkg::CTRL_OFFSET, {24'h00_0000, v});
    repeat (5) @(posedge clk);
  endtask
  // pulses held two cycles each way so the synchroniser cannot miss them
  task automatic capture(input logic [7:0] av, bv);
    a_val <= av;
    b_val <= bv;
    repeat (2) @(posedge clk);
    cap_a <= 1'b1;
    cap_b <= 1'b1;
    repeat (2) @(posedge clk);
    cap_a <= 1'b0;
    cap_b <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic complete_run;
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  // a hang is cut off well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, xcvr_pkg::CTRL_OFFSET, 32'h0000_0000);
    check("ctrl", 32'h0000_0001, rd);
    check("oe", 2'b00, {a_oe, b_oe});
    a_val <= 8'h3c;
    b_val <= 8'ha5;
    ctrl(8'h00);
    check("oe", 2'b10, {a_oe, b_oe});
    check("a_out", 8'ha5, a_out);
    ctrl(8'h02);
    check("oe", 2'b01, {a_oe, b_oe});
    check("b_out", 8'h3c, b_out);
    ctrl(8'h01);
    capture(8'h5a, 8'hc3);
    apb(1'b0, xcvr_pkg::STORE_OFFSET, 32'h0000_0000);
    check("store", 32'h0000_c35a, rd);
    check("oe", 2'b00, {a_oe, b_oe});
    b_val <= 8'h11;
    ctrl(8'h08);
    check("a_out", 8'hc3, a_out);
    // bus a carries the device's own drive, bus b the far party's level
    apb(1'b0, xcvr_pkg::LIVE_OFFSET, 32'h0000_0000);
    check("live", 32'h0000_11c3, rd);
    a_val <= 8'h22;
    ctrl(8'h06);
    check("b_out", 8'h5a, b_out);
    ctrl(8'h02);
    check("b_out", 8'h22, b_out);
    ctrl(8'h18);
    check("a_out", 8'h3c, a_out);
    ctrl(8'h10);
    check("a_out", 8'hee, a_out);
    b_val <= 8'hc3;
    ctrl(8'h00);
    apb(1'b1, xcvr_pkg::CTRL_OFFSET, 32'h0000_0008);
    // same value live and stored: any blip on the switch is a fault
    repeat (6) begin
      @(posedge clk);
      check("a_out", 8'hc3, a_out);
    end
    apb(1'b0, 12'h00c, 32'h0000_0000);
    check("err", 1'b1, err);
    check("rdata", 32'h0000_0000, rd);
    apb(1'b1, xcvr_pkg::STORE_OFFSET, 32'hffff_ffff);
    apb(1'b0, xcvr_pkg::STORE_OFFSET, 32'h0000_0000);
    check("store", 32'h0000_c35a, rd);
    complete_run();
  end
endmodule
